//--- rtl/drsd_regs.vh
`ifndef DRSD_REGS_VH
`define DRSD_REGS_VH

// register byte offsets
`define DRSD_CMD_OFS      8'h00
`define DRSD_STATUS_OFS   8'h04
`define DRSD_OP_OFS       8'h08
`define DRSD_RECT_OFS     8'h0C
`define DRSD_CLRVAL_OFS   8'h10
`define DRSD_STENCIL_OFS  8'h14
`define DRSD_COUNT_OFS    8'h18

// packet header fields and expected codes
`define DRSD_HDR_TYPE_HI   31
`define DRSD_HDR_TYPE_LO   29
`define DRSD_HDR_SUB_HI    28
`define DRSD_HDR_SUB_LO    27
`define DRSD_HDR_OPC_HI    26
`define DRSD_HDR_OPC_LO    24
`define DRSD_HDR_SOPC_HI   23
`define DRSD_HDR_SOPC_LO   16
`define DRSD_HDR_LEN_HI    7
`define DRSD_HDR_LEN_LO    0
`define DRSD_GRAPHICS_COMMAND_TYPE    3'h3
`define DRSD_THREE_D_COMMAND_SUBTYPE  2'h3
`define DRSD_UNPIPELINED_STATE_OPCODE 3'h1
`define DRSD_DEPTH_SURFACE_SUB_OPCODE 8'h05
`define DRSD_LENGTH_BIAS              8'h02

// dword 1 fields
`define DRSD_TILED_BIT    27
`define DRSD_WALK_BIT     26

// operation register fields and modes
`define DRSD_OP_START_BIT 0
`define DRSD_OP_MODE_HI   2
`define DRSD_OP_MODE_LO   1
`define DRSD_MODE_DEPTH_RESOLVE 2'h0
`define DRSD_MODE_HIER_RESOLVE  2'h1
`define DRSD_MODE_HIER_OP_PKT   2'h2

// status bit positions
`define DRSD_ST_BUSY      0
`define DRSD_ST_TILED     1
`define DRSD_ST_WALK      2
`define DRSD_ST_LIN_ERR   3
`define DRSD_ST_WALK_ERR  4
`define DRSD_ST_HDR_MISS  5
`define DRSD_ST_PKT_ACT   6

// stencil
`define DRSD_EIGHT_BIT_STENCIL_FORMAT 8'h01
`define DRSD_CLRVAL_RESET 32'h0000_0000

`endif

//--- rtl/drsd_top.v
// Notes on behaviour
// - depth resolve rewrites every fast-cleared block inside the rect register's rectangle so depth matches plain rendering.
// - after foreign depth writes, hier resolve rebuilds hierarchy to match plain rendering.
// - hier resolve also accepted via hier operation packet, same sequence.
// - separate stencil is eight-bit, column-major tiled, geometry inherited from depth.
// - stencil mip level ignored, forced zero; producer resends per level.
// - stencil held inside depth buffer remains supported.
// - surface packet is unpipelined state, length field biased by two dwords.
// - header matched on type, subtype, opcode and sub-opcode fields of dword 0.
// - tiled bit 27 must be one; linear surface flagged as error.
// - walk bit 26 must be column-major when tiled; ignored when linear.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "drsd_regs.vh"

module drsd_top #(
    parameter BX_MAX = 16,
    parameter BY_MAX = 16,
    parameter BLK_W  = 8
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire              hreadyout,
    output wire              hresp,
    output reg  [31:0]       hrdata,
    input  wire              blk_clear_valid,
    input  wire [BLK_W-1:0]  blk_clear_idx,
    output wire              depth_wr_valid,
    input  wire              depth_wr_ready,
    output reg  [BLK_W-1:0]  depth_wr_blk,
    output reg  [31:0]       depth_wr_data,
    output reg               hier_rebuild_valid,
    output reg  [BLK_W-1:0]  hier_rebuild_blk,
    output reg               op_done,
    output wire              surf_tiled,
    output wire              surf_column_major_walk,
    output wire              stencil_separate_en,
    output wire [7:0]        stencil_format,
    output wire [3:0]        stencil_lod,
    output wire              stencil_in_depth
);
    localparam NBLK = BX_MAX * BY_MAX;
    localparam S_IDLE = 2'h0;
    localparam S_SCAN = 2'h1;
    localparam S_WR   = 2'h2;
    localparam S_DONE = 2'h3;

    reg              dph_wr_ff;
    reg              dph_rd_ff;
    reg  [7:0]       dph_addr_ff;
    reg  [1:0]       state_ff;
    reg  [1:0]       mode_ff;
    reg  [7:0]       bx_ff;
    reg  [7:0]       by_ff;
    reg  [7:0]       rect_w_ff;
    reg  [7:0]       rect_h_ff;
    reg  [31:0]      clrval_ff;
    reg              stencil_en_ff;
    reg  [3:0]       lod_ff;
    reg              pkt_act_ff;
    reg  [7:0]       pkt_left_ff;
    reg              pkt_first_ff;
    reg              tiled_ff;
    reg              walk_ff;
    reg              hdr_miss_ff;
    reg  [15:0]      wr_count_ff;
    reg  [NBLK-1:0]  hz_cleared_ff;
    reg  [NBLK-1:0]  blk_wipe;
    reg  [1:0]       nxt_state;
    reg  [7:0]       nxt_bx;
    reg  [7:0]       nxt_by;
    reg  [BLK_W-1:0] cur_blk;
    reg  [31:0]      rd_mux;
    wire             busy;
    wire             addr_ok;
    wire             cmd_wr;
    wire             cmd_go;
    wire             op_go;
    wire             hdr_match;
    wire             last_x;
    wire             last_y;
    wire [7:0]       hdr_len;

    assign busy = (state_ff != S_IDLE);
    assign addr_ok = hsel & htrans[1] & hready;
    assign cmd_wr = dph_wr_ff & (dph_addr_ff == `DRSD_CMD_OFS);
    assign cmd_go = cmd_wr & ~busy;
    assign hreadyout = ~(cmd_wr & busy);
    assign hresp = 1'b0;
    assign op_go = dph_wr_ff & (dph_addr_ff == `DRSD_OP_OFS) & ~busy
                   & hwdata[`DRSD_OP_START_BIT]
                   & (hwdata[`DRSD_OP_MODE_HI:`DRSD_OP_MODE_LO] != 2'h3);

    assign hdr_match =
        (hwdata[`DRSD_HDR_TYPE_HI:`DRSD_HDR_TYPE_LO] == `DRSD_GRAPHICS_COMMAND_TYPE) &
        (hwdata[`DRSD_HDR_SUB_HI:`DRSD_HDR_SUB_LO] == `DRSD_THREE_D_COMMAND_SUBTYPE) &
        (hwdata[`DRSD_HDR_OPC_HI:`DRSD_HDR_OPC_LO] == `DRSD_UNPIPELINED_STATE_OPCODE) &
        (hwdata[`DRSD_HDR_SOPC_HI:`DRSD_HDR_SOPC_LO] == `DRSD_DEPTH_SURFACE_SUB_OPCODE);
    assign hdr_len = hwdata[`DRSD_HDR_LEN_HI:`DRSD_HDR_LEN_LO];

    // bus address phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_ff <= 1'b0;
            dph_rd_ff <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else if (hready) begin
            dph_wr_ff <= addr_ok & hwrite;
            dph_rd_ff <= addr_ok & ~hwrite;
            dph_addr_ff <= {haddr[7:2], 2'b00};
        end
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        case ({haddr[7:2], 2'b00})
            `DRSD_STATUS_OFS: begin
                rd_mux[`DRSD_ST_BUSY] = busy;
                rd_mux[`DRSD_ST_TILED] = tiled_ff;
                rd_mux[`DRSD_ST_WALK] = walk_ff;
                rd_mux[`DRSD_ST_LIN_ERR] = ~tiled_ff;
                rd_mux[`DRSD_ST_WALK_ERR] = tiled_ff & ~walk_ff;
                rd_mux[`DRSD_ST_HDR_MISS] = hdr_miss_ff;
                rd_mux[`DRSD_ST_PKT_ACT] = pkt_act_ff;
            end
            `DRSD_OP_OFS: rd_mux[2:1] = mode_ff;
            `DRSD_RECT_OFS: rd_mux = {8'h00, rect_h_ff, 8'h00, rect_w_ff};
            `DRSD_CLRVAL_OFS: rd_mux = clrval_ff;
            `DRSD_STENCIL_OFS: rd_mux = {27'h000_0000, lod_ff, stencil_en_ff};
            `DRSD_COUNT_OFS: rd_mux = {16'h0000, wr_count_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered at address phase, stands in data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok & ~hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // software configuration registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rect_w_ff <= 8'h00;
            rect_h_ff <= 8'h00;
            clrval_ff <= `DRSD_CLRVAL_RESET;
            stencil_en_ff <= 1'b0;
            lod_ff <= 4'h0;
            mode_ff <= 2'h0;
        end else if (dph_wr_ff) begin
            if (dph_addr_ff == `DRSD_RECT_OFS) begin
                rect_w_ff <= hwdata[7:0];
                rect_h_ff <= hwdata[23:16];
            end
            if (dph_addr_ff == `DRSD_CLRVAL_OFS) begin
                clrval_ff <= hwdata;
            end
            if (dph_addr_ff == `DRSD_STENCIL_OFS) begin
                stencil_en_ff <= hwdata[0];
                lod_ff <= hwdata[4:1];
            end
            if (op_go) begin
                mode_ff <= hwdata[`DRSD_OP_MODE_HI:`DRSD_OP_MODE_LO];
            end
        end
    end

    // surface state packet parser
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pkt_act_ff <= 1'b0;
            pkt_left_ff <= 8'h00;
            pkt_first_ff <= 1'b0;
            tiled_ff <= 1'b1;
            walk_ff <= 1'b1;
            hdr_miss_ff <= 1'b0;
        end else begin
            if (cmd_go & ~pkt_act_ff & ~hdr_match) begin
                hdr_miss_ff <= 1'b1;
            end else if (dph_wr_ff & (dph_addr_ff == `DRSD_STATUS_OFS)
                         & hwdata[`DRSD_ST_HDR_MISS]) begin
                hdr_miss_ff <= 1'b0;
            end
            if (cmd_go & ~pkt_act_ff & hdr_match) begin
                pkt_act_ff <= 1'b1;
                pkt_first_ff <= 1'b1;
                // total dwords = length + 2, header already taken
                pkt_left_ff <= hdr_len + `DRSD_LENGTH_BIAS - 8'h01;
            end else if (cmd_go & pkt_act_ff) begin
                pkt_first_ff <= 1'b0;
                pkt_left_ff <= pkt_left_ff - 8'h01;
                if (pkt_left_ff == 8'h01) begin
                    pkt_act_ff <= 1'b0;
                end
                if (pkt_first_ff) begin
                    tiled_ff <= hwdata[`DRSD_TILED_BIT];
                    walk_ff <= hwdata[`DRSD_WALK_BIT];
                end
            end
        end
    end

    assign surf_column_major_walk = tiled_ff & walk_ff;
    assign surf_tiled = tiled_ff;
    // eight-bit stencil, column-major only, depth geometry
    assign stencil_separate_en = stencil_en_ff & tiled_ff & walk_ff;
    assign stencil_format = `DRSD_EIGHT_BIT_STENCIL_FORMAT;
    // stencil mip level forced to zero
    assign stencil_lod = 4'h0;
    assign stencil_in_depth = ~stencil_separate_en;

    assign last_x = (bx_ff + 8'h01 >= rect_w_ff) | (bx_ff == BX_MAX - 1);
    assign last_y = (by_ff + 8'h01 >= rect_h_ff) | (by_ff == BY_MAX - 1);

    always @* begin
        cur_blk = by_ff[BLK_W-1:0] * BX_MAX[BLK_W-1:0] + bx_ff[BLK_W-1:0];
    end

    // block walker
    always @* begin
        nxt_state = state_ff;
        nxt_bx = bx_ff;
        nxt_by = by_ff;
        case (state_ff)
            S_IDLE: begin
                if (op_go) begin
                    nxt_bx = 8'h00;
                    nxt_by = 8'h00;
                    nxt_state = S_SCAN;
                end
            end
            S_SCAN: begin
                // only stale blocks need a depth write
                if ((mode_ff == `DRSD_MODE_DEPTH_RESOLVE) & hz_cleared_ff[cur_blk]) begin
                    nxt_state = S_WR;
                end else if (last_x & last_y) begin
                    nxt_state = S_DONE;
                end else if (last_x) begin
                    nxt_bx = 8'h00;
                    nxt_by = by_ff + 8'h01;
                end else begin
                    nxt_bx = bx_ff + 8'h01;
                end
            end
            S_WR: begin
                if (depth_wr_ready) begin
                    if (last_x & last_y) begin
                        nxt_state = S_DONE;
                    end else if (last_x) begin
                        nxt_bx = 8'h00;
                        nxt_by = by_ff + 8'h01;
                        nxt_state = S_SCAN;
                    end else begin
                        nxt_bx = bx_ff + 8'h01;
                        nxt_state = S_SCAN;
                    end
                end
            end
            S_DONE: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    assign depth_wr_valid = (state_ff == S_WR);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= S_IDLE;
            bx_ff <= 8'h00;
            by_ff <= 8'h00;
            depth_wr_blk <= {BLK_W{1'b0}};
            depth_wr_data <= 32'h0000_0000;
            hier_rebuild_valid <= 1'b0;
            hier_rebuild_blk <= {BLK_W{1'b0}};
            op_done <= 1'b0;
            wr_count_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            bx_ff <= nxt_bx;
            by_ff <= nxt_by;
            op_done <= (state_ff == S_DONE);
            if (op_go) begin
                wr_count_ff <= 16'h0000;
            end
            if (nxt_state == S_WR && state_ff == S_SCAN) begin
                // resolved value is the clear value
                depth_wr_blk <= cur_blk;
                depth_wr_data <= clrval_ff;
            end
            if (depth_wr_valid & depth_wr_ready) begin
                wr_count_ff <= wr_count_ff + 16'h0001;
            end
            // packet path shares the same walk
            hier_rebuild_valid <= (state_ff == S_SCAN) & (mode_ff != `DRSD_MODE_DEPTH_RESOLVE);
            hier_rebuild_blk <= cur_blk;
        end
    end

    // which blocks the resolve clears; set from pipeline wins
    always @* begin
        blk_wipe = {NBLK{1'b0}};
        if ((state_ff == S_WR) & depth_wr_ready) begin
            blk_wipe[cur_blk] = 1'b1;
        end
        if ((state_ff == S_SCAN) & (mode_ff != `DRSD_MODE_DEPTH_RESOLVE)) begin
            blk_wipe[cur_blk] = 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NBLK; gi = gi + 1) begin : g_blk
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hz_cleared_ff[gi] <= 1'b0;
                end else if (blk_clear_valid && blk_clear_idx == gi) begin
                    hz_cleared_ff[gi] <= 1'b1;
                end else if (blk_wipe[gi]) begin
                    hz_cleared_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

//--- test/drsd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module drsd_mem_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        slow,
    input  wire logic        depth_wr_valid,
    input  wire logic [7:0]  depth_wr_blk,
    input  wire logic [31:0] depth_wr_data,
    output logic             depth_wr_ready
);
    int          n_wr;
    logic [7:0]  blk_log [0:7];
    logic [31:0] last_data;
    logic [1:0]  wait_ff;

    // slow mode holds ready off for three cycles of a standing request
    assign depth_wr_ready = depth_wr_valid && (!slow || wait_ff == 2'h3);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_wr <= 0;
            wait_ff <= 2'h0;
            last_data <= 32'h0000_0000;
        end else if (depth_wr_valid && depth_wr_ready) begin
            blk_log[n_wr[2:0]] <= depth_wr_blk;
            last_data <= depth_wr_data;
            n_wr <= n_wr + 1;
            wait_ff <= 2'h0;
        end else if (depth_wr_valid) begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
endmodule
`default_nettype wire

//--- test/drsd_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module drsd_top_chk #(
    parameter BLK_W = 8
) (
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             depth_wr_valid,
    input wire logic             depth_wr_ready,
    input wire logic [BLK_W-1:0] depth_wr_blk,
    input wire logic [31:0]      depth_wr_data,
    input wire logic             hier_rebuild_valid,
    input wire logic             op_done,
    input wire logic             surf_tiled,
    input wire logic             surf_column_major_walk,
    input wire logic             stencil_separate_en,
    input wire logic [7:0]       stencil_format,
    input wire logic [3:0]       stencil_lod,
    input wire logic             stencil_in_depth
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wr_hold_a: assert property (
        depth_wr_valid && !depth_wr_ready |=> depth_wr_valid && $stable(depth_wr_blk)
        && $stable(depth_wr_data)) else $error("depth write changed before ready");
    done_pulse_a: assert property (op_done |=> !op_done)
        else $error("done longer than one cycle");
    rebuild_excl_a: assert property (hier_rebuild_valid |-> !depth_wr_valid)
        else $error("rebuild during depth write");
    stencil_fmt_a: assert property (stencil_separate_en |-> stencil_format == 8'h01)
        else $error("stencil format wrong");
    stencil_tile_a: assert property (
        stencil_separate_en |-> surf_tiled && surf_column_major_walk)
        else $error("separate stencil on untiled surface");
    stencil_lod_a: assert property (stencil_lod == 4'h0)
        else $error("stencil level not zero");
    stencil_path_a: assert property (stencil_in_depth != stencil_separate_en)
        else $error("stencil path flags disagree");
    walk_ignore_a: assert property (!surf_tiled |-> !surf_column_major_walk)
        else $error("walk shown on linear surface");
endmodule
bind drsd_top drsd_top_chk #(.BLK_W(BLK_W)) u_drsd_top_chk (
    .hclk(hclk), .hresetn(hresetn), .depth_wr_valid(depth_wr_valid),
    .depth_wr_ready(depth_wr_ready), .depth_wr_blk(depth_wr_blk),
    .depth_wr_data(depth_wr_data), .hier_rebuild_valid(hier_rebuild_valid),
    .op_done(op_done), .surf_tiled(surf_tiled),
    .surf_column_major_walk(surf_column_major_walk),
    .stencil_separate_en(stencil_separate_en), .stencil_format(stencil_format),
    .stencil_lod(stencil_lod), .stencil_in_depth(stencil_in_depth));
`default_nettype wire

//--- test/drsd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "drsd_regs.vh"
module drsd_top_tb;
    logic        hclk, hresetn, hsel, hwrite, blk_clear_valid, slow;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  blk_clear_idx;
    wire         hready, hreadyout, depth_wr_valid, depth_wr_ready, hier_rebuild_valid;
    wire         op_done, surf_tiled, surf_column_major_walk, stencil_separate_en;
    wire         stencil_in_depth;
    wire [31:0]  hrdata, depth_wr_data;
    wire [7:0]   depth_wr_blk, stencil_format, hier_rebuild_blk;
    wire [3:0]   stencil_lod;
    int          error_cnt, n_checks, n_done, n_rebuild, rb_sum, i;
    logic [31:0] bad_hdr [0:3];

    assign hready = hreadyout;

    drsd_top u_drsd_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .blk_clear_valid(blk_clear_valid), .blk_clear_idx(blk_clear_idx),
        .depth_wr_valid(depth_wr_valid), .depth_wr_ready(depth_wr_ready),
        .depth_wr_blk(depth_wr_blk), .depth_wr_data(depth_wr_data),
        .hier_rebuild_valid(hier_rebuild_valid), .hier_rebuild_blk(hier_rebuild_blk),
        .op_done(op_done),
        .surf_tiled(surf_tiled), .surf_column_major_walk(surf_column_major_walk),
        .stencil_separate_en(stencil_separate_en), .stencil_format(stencil_format),
        .stencil_lod(stencil_lod), .stencil_in_depth(stencil_in_depth));

    drsd_mem_model u_drsd_mem_model (
        .hclk(hclk), .hresetn(hresetn), .slow(slow), .depth_wr_valid(depth_wr_valid),
        .depth_wr_blk(depth_wr_blk), .depth_wr_data(depth_wr_data),
        .depth_wr_ready(depth_wr_ready));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (op_done === 1'b1)
            n_done++;
        if (hier_rebuild_valid === 1'b1) begin
            n_rebuild++;
            rb_sum += hier_rebuild_blk;
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic stuck(input string m);
        error_cnt++;
        $display("unexpected at %0t: %s wait ran out", $time, m);
        conclude();
    endtask

    // waits are bounded: a stalled command may last a whole slow operation
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        @(posedge hclk);
        while (hready !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        r = hrdata;
        if (n >= 400)
            stuck("bus");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r, e, m);
    endtask

    task automatic pkt(input logic [31:0] d1);
        wr(`DRSD_CMD_OFS, 32'h7905_0000);
        wr(`DRSD_CMD_OFS, d1);
    endtask

    task automatic wait_done(input int k);
        int n;
        for (n = 0; n < 300 && n_done < k; n++)
            @(posedge hclk);
        if (n_done < k)
            stuck("done");
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        blk_clear_valid = 1'b0;
        blk_clear_idx = 8'h00;
        slow = 1'b0;
        bad_hdr = '{32'h5905_0000, 32'h6905_0000, 32'h7a05_0000, 32'h7906_0000};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`DRSD_STATUS_OFS, 32'h0000_0006, "reset status");
        chk({31'h0, stencil_in_depth}, 32'h0000_0001, "stencil in depth");
        $display("test reset done");
        // length field one: header plus two dwords
        wr(`DRSD_CMD_OFS, 32'h7905_0001);
        wr(`DRSD_CMD_OFS, 32'h0c00_0000);
        rd(`DRSD_STATUS_OFS, 32'h0000_0046, "packet open");
        wr(`DRSD_CMD_OFS, 32'h0000_0000);
        rd(`DRSD_STATUS_OFS, 32'h0000_0006, "packet closed");
        pkt(32'h0400_0000);
        rd(`DRSD_STATUS_OFS, 32'h0000_000c, "linear surface");
        chk({31'h0, surf_column_major_walk}, 32'h0000_0000, "walk when linear");
        pkt(32'h0800_0000);
        rd(`DRSD_STATUS_OFS, 32'h0000_0012, "reserved walk");
        pkt(32'h0c00_0000);
        $display("test surface done");
        for (i = 0; i < 4; i++) begin
            wr(`DRSD_CMD_OFS, bad_hdr[i]);
            rd(`DRSD_STATUS_OFS, 32'h0000_0026, "bad header");
            wr(`DRSD_STATUS_OFS, 32'h0000_0020);
            rd(`DRSD_STATUS_OFS, 32'h0000_0006, "miss cleared");
        end
        $display("test header done");
        wr(`DRSD_STENCIL_OFS, 32'h0000_000b);
        rd(`DRSD_STENCIL_OFS, 32'h0000_000b, "stencil reg");
        chk({24'h0, stencil_format}, 32'h0000_0001, "stencil format");
        chk({28'h0, stencil_lod}, 32'h0000_0000, "stencil level");
        chk({31'h0, stencil_separate_en}, 32'h0000_0001, "stencil sep");
        pkt(32'h0000_0000);
        // tiled bit lands at the edge the write ends on; look one cycle later
        @(posedge hclk);
        chk({31'h0, stencil_separate_en}, 32'h0000_0000, "stencil linear");
        pkt(32'h0c00_0000);
        $display("test stencil done");
        wr(`DRSD_CLRVAL_OFS, 32'hdead_beef);
        wr(`DRSD_RECT_OFS, 32'h0002_0004);
        blk_clear_valid <= 1'b1;
        blk_clear_idx <= 8'h11;
        @(posedge hclk);
        blk_clear_idx <= 8'h01;
        @(posedge hclk);
        blk_clear_idx <= 8'h28;
        @(posedge hclk);
        blk_clear_valid <= 1'b0;
        slow <= 1'b1;
        wr(`DRSD_OP_OFS, 32'h0000_0001);
        wr(`DRSD_CMD_OFS, 32'h7905_0000);
        chk(u_drsd_mem_model.n_wr, 32'h0000_0002, "writes before stall end");
        chk({24'h0, u_drsd_mem_model.blk_log[0]}, 32'h0000_0001, "first block");
        chk({24'h0, u_drsd_mem_model.blk_log[1]}, 32'h0000_0011, "second block");
        chk(u_drsd_mem_model.last_data, 32'hdead_beef, "written depth");
        wr(`DRSD_CMD_OFS, 32'h0c00_0000);
        rd(`DRSD_COUNT_OFS, 32'h0000_0002, "resolve count");
        chk(n_done, 32'h0000_0001, "done pulses");
        $display("test resolve done");
        slow <= 1'b0;
        for (i = 1; i < 3; i++) begin
            blk_clear_valid <= 1'b1;
            blk_clear_idx <= 8'h02;
            @(posedge hclk);
            blk_clear_valid <= 1'b0;
            n_rebuild = 0;
            rb_sum = 0;
            wr(`DRSD_OP_OFS, {29'h0, i[1:0], 1'b1});
            wait_done(i + 1);
            chk(n_rebuild, 32'h0000_0008, "rebuild blocks");
            // blocks 0..3 and 16..19 of a 4x2 rectangle
            chk(rb_sum, 32'h0000_004c, "rebuild block sum");
            rd(`DRSD_COUNT_OFS, 32'h0000_0000, "hier count");
        end
        wr(`DRSD_OP_OFS, 32'h0000_0007);
        rd(`DRSD_OP_OFS, 32'h0000_0004, "mode three ignored");
        wr(`DRSD_OP_OFS, 32'h0000_0001);
        wait_done(4);
        rd(`DRSD_COUNT_OFS, 32'h0000_0000, "blocks already clean");
        chk(u_drsd_mem_model.n_wr, 32'h0000_0002, "no extra writes");
        $display("test hier done");
        conclude();
    end
endmodule
`default_nettype wire
